//--- core/prx_cfg.svh
// Offsets, field positions, reset values and limits of the lane alignment status block
`ifndef PRX_CFG_SVH
`define PRX_CFG_SVH

// ****************************************************************
// Register map (byte addresses, 32-bit words)
// ****************************************************************
`define PRX_AW 12
`define PRX_OFF_CTRL 12'h000
`define PRX_OFF_LOCK 12'h004
`define PRX_OFF_IST 12'h008
`define PRX_OFF_IEN 12'h00C
`define PRX_OFF_ICLR 12'h010

// ****************************************************************
// Field positions
// ****************************************************************
`define PRX_LK_LOCK 0
`define PRX_LK_SERR 4
`define PRX_LK_IDX 8
`define PRX_EV_BIP 0
`define PRX_EV_SP 4
`define PRX_EV_REP 8
`define PRX_EV_FALL 12

// ****************************************************************
// Widths, reset values and counts
// ****************************************************************
`define PRX_LANES 4
`define PRX_IVW 16
`define PRX_EVW 16
`define PRX_IVL_RST 16'h3FFF
`define PRX_REP_LAST 2'h3

`endif

//--- core/prx_lane_align_status.sv
// Receive lane alignment status with lane mapping, error pulses and an APB register file
//
// Function
// R1: Each PCS lane, lanes 2 and 3 included, has a 2-bit bus naming the physical lane mapped on it.
// R2: A mapping bus is a steady level and only meaningful while that lane's marker lock is 1.
// R3: A failed parity check on a PCS lane gives a non-zero value on its error output for one cycle.
// R4: A lock bit per PCS lane is 1 while it has word lock and has received a marker, else 0.
// R5: The four lock bits mirror the standard lane alignment status fields.
// R6: A sync error level is 1 when a lane lost word lock or never received a marker.
// R7: A spacing error bit pulses one cycle when markers miss the configured interval.
// R8: A repeat error bit pulses one cycle on four marker errors in a row on a lane.
// R9: Parity error outputs are assigned in lane index order, output n for PCS lane n.
//
// The address map and the APB slave port were chosen for this implementation.
`include "prx_cfg.svh"

module prx_lane_align_status
    import prx_pkg::*;
#(
    parameter int LANES = `PRX_LANES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PRX_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire prx_word_s [3:0] lane_in,
    output logic [3:0] lane_marker_lock,
    output logic [3:0] sync_error,
    output logic [3:0] marker_spacing_error,
    output logic [3:0] marker_repeat_error,
    output logic [3:0][7:0] bip_error,
    output logic [1:0] pcs_lane0_phys_index,
    output logic [1:0] pcs_lane1_phys_index,
    output logic [1:0] pcs_lane2_phys_index,
    output logic [1:0] pcs_lane3_phys_index
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The 2-bit mapping buses and fixed ports only serve four lanes
    if (LANES != `PRX_LANES) begin : g_bad_lanes
        $error("prx_lane_align_status supports exactly four lanes");
    end

    prx_top_s s_reg;
    prx_top_s s_next;
    prx_lane_s [3:0] trk;

    logic setup;
    logic access;
    logic mapped;
    logic [`PRX_EVW-1:0] ev;
    logic [`PRX_EVW-1:0] clr;
    logic [31:0] rd;

    // ****************************************************************
    // One tracker per physical lane
    // ****************************************************************
    for (genvar p = 0; p < LANES; p++) begin : g_lane
        prx_lane_tracker u_trk (
            .pclk(pclk),
            .presetn(presetn),
            .ivl(s_reg.marker_interval_minus_one),
            .w(lane_in[p]),
            .st(trk[p])
        );
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Zero wait state: pready rises in the first access cycle
    assign setup = psel & ~penable;
    assign access = psel & penable & s_reg.pready;

    // Address map; misaligned or unknown offsets answer with an error
    always_comb begin
        mapped = 1'b1;
        rd = 32'h0000_0000;
        case (paddr)
            `PRX_OFF_CTRL: begin
                rd[`PRX_IVW-1:0] = s_reg.marker_interval_minus_one;
            end
            `PRX_OFF_LOCK: begin
                rd[`PRX_LK_LOCK +: 4] = s_reg.lock; // R5
                rd[`PRX_LK_SERR +: 4] = s_reg.serr;
                rd[`PRX_LK_IDX +: 8] = s_reg.idx;
            end
            `PRX_OFF_IST: begin
                rd[`PRX_EVW-1:0] = s_reg.ist;
            end
            `PRX_OFF_IEN: begin
                rd[`PRX_EVW-1:0] = s_reg.ien;
            end
            `PRX_OFF_ICLR: begin
                rd = 32'h0000_0000; // Write-only, reads as zero
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Interrupt events
    // ****************************************************************
    // Clear mask of a completing write to the clear register; the events
    // are gathered inside the next-state process so no loop forms through it
    always_comb begin
        clr = '0;
        if (access && pwrite && paddr == `PRX_OFF_ICLR) begin
            clr = pwdata[`PRX_EVW-1:0];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_next = s_reg;

        // Map physical lane status onto PCS lanes by the marker id each carries
        for (int v = 0; v < LANES; v++) begin
            s_next.lock[v] = 1'b0;
            s_next.sp[v] = 1'b0;
            s_next.rep[v] = 1'b0;
            s_next.bip[v] = 8'h00;
            for (int p = 0; p < LANES; p++) begin
                if (trk[p].id == v[1:0]) begin
                    if (trk[p].lock) begin // R2
                        s_next.lock[v] = 1'b1; // R4
                        s_next.idx[v] = p[1:0]; // R1
                    end
                    s_next.sp[v] = s_next.sp[v] | trk[p].sp_err; // R7
                    s_next.rep[v] = s_next.rep[v] | trk[p].rep_err; // R8
                    s_next.bip[v] = s_next.bip[v] | trk[p].bip; // R3
                end
            end
            // Lost framing and a never-seen marker both leave lock low
            s_next.serr[v] = ~s_next.lock[v]; // R6
        end

        // Events come from the values about to be registered so the
        // status bit and the error pulse appear together
        ev = '0;
        for (int v = 0; v < LANES; v++) begin
            ev[`PRX_EV_BIP + v] = |s_next.bip[v];
            ev[`PRX_EV_SP + v] = s_next.sp[v];
            ev[`PRX_EV_REP + v] = s_next.rep[v];
            ev[`PRX_EV_FALL + v] = s_reg.lock[v] & ~s_next.lock[v];
        end

        // Sticky status: a new event wins over a clear in the same cycle
        s_next.ist = (s_reg.ist & ~clr) | ev;

        // Software writes take effect only at the completing access edge
        if (access && pwrite) begin
            case (paddr)
                `PRX_OFF_CTRL: begin
                    s_next.marker_interval_minus_one = pwdata[`PRX_IVW-1:0];
                end
                `PRX_OFF_IEN: begin
                    s_next.ien = pwdata[`PRX_EVW-1:0];
                end
                default: begin
                    s_next.ien = s_reg.ien;
                end
            endcase
        end

        s_next.irq = |(s_next.ist & s_next.ien);

        // Answer is prepared in the setup cycle and shown in the access cycle
        s_next.pready = setup;
        s_next.pslverr = setup & ~mapped;
        if (setup && !pwrite) begin
            s_next.prdata = rd;
        end else if (access) begin
            s_next.prdata = 32'h0000_0000;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.marker_interval_minus_one <= `PRX_IVL_RST;
            s_reg.serr <= 4'hF;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs, all straight from the state register
    // ****************************************************************
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign irq = s_reg.irq;
    assign lane_marker_lock = s_reg.lock; // R2
    assign sync_error = s_reg.serr;
    assign marker_spacing_error = s_reg.sp;
    assign marker_repeat_error = s_reg.rep;
    assign bip_error = s_reg.bip; // R9
    assign pcs_lane0_phys_index = s_reg.idx[0];
    assign pcs_lane1_phys_index = s_reg.idx[1];
    assign pcs_lane2_phys_index = s_reg.idx[2]; // R1
    assign pcs_lane3_phys_index = s_reg.idx[3]; // R1

endmodule : prx_lane_align_status

//--- core/prx_lane_tracker.sv
// Marker spacing, repeat error, parity check and lock tracking of one physical lane
`include "prx_cfg.svh"

module prx_lane_tracker
    import prx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`PRX_IVW-1:0] ivl,
    input wire prx_word_s w,
    output prx_lane_s st
);

    prx_trk_s r_reg;
    prx_trk_s r_next;
    logic bad;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        r_next = r_reg;
        bad = 1'b0;
        r_next.st.sp_err = 1'b0;
        r_next.st.rep_err = 1'b0;
        r_next.st.bip = 8'h00;
        if (!w.hdr_lock) begin
            // Lost framing drops the marker history too
            r_next.seen = 1'b0;
            r_next.cnt = '0;
            r_next.errs = 2'h0;
        end else if (w.word_vld) begin
            if (w.marker) begin
                if (r_reg.seen) begin
                    r_next.st.bip = w.bip_calc ^ w.bip_rx; // R3
                    bad = (r_reg.cnt != ivl); // R7
                end
                r_next.seen = 1'b1;
                r_next.st.id = w.marker_id;
                r_next.cnt = '0;
            end else if (r_reg.seen) begin
                if (r_reg.cnt == ivl) begin
                    // Missing marker: restart the window at the expected slot
                    bad = 1'b1; // R7
                    r_next.cnt = '0;
                end else begin
                    r_next.cnt = r_reg.cnt + 16'h0001;
                end
            end
        end
        // Consecutive error count; a good marker restarts it
        if (bad) begin
            r_next.st.sp_err = 1'b1; // R7
            if (r_reg.errs == `PRX_REP_LAST) begin
                r_next.st.rep_err = 1'b1; // R8
                r_next.errs = 2'h0;
            end else begin
                r_next.errs = r_reg.errs + 2'h1;
            end
        end else if (w.hdr_lock && w.word_vld && w.marker) begin
            r_next.errs = 2'h0;
        end
        r_next.st.lock = w.hdr_lock & r_next.seen; // R4
        r_next.st.sync_err = ~r_next.st.lock; // R6
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.st.sync_err <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign st = r_reg.st;

endmodule : prx_lane_tracker

//--- core/prx_pkg.sv
// Types shared by the lane alignment status block and its lane tracker
package prx_pkg;

    // ****************************************************************
    // Per physical lane word stream from the receive datapath
    // ****************************************************************
    typedef struct packed {
        logic hdr_lock;
        logic word_vld;
        logic marker;
        logic [1:0] marker_id;
        logic [7:0] bip_calc;
        logic [7:0] bip_rx;
    } prx_word_s;

    // Status of one physical lane as seen by its tracker
    typedef struct packed {
        logic lock;
        logic sync_err;
        logic [1:0] id;
        logic sp_err;
        logic rep_err;
        logic [7:0] bip;
    } prx_lane_s;

    // Whole state of one tracker
    typedef struct packed {
        logic [15:0] cnt;
        logic seen;
        logic [1:0] errs;
        prx_lane_s st;
    } prx_trk_s;

    // Whole state of the top module
    typedef struct packed {
        logic [15:0] marker_interval_minus_one;
        logic [15:0] ien;
        logic [15:0] ist;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [3:0] lock;
        logic [3:0] serr;
        logic [3:0] sp;
        logic [3:0] rep;
        logic [3:0][7:0] bip;
        logic [3:0][1:0] idx;
    } prx_top_s;

endpackage : prx_pkg

//--- testbench/prx_lane_align_status_bench.sv
// Bench of the lane alignment status block with APB tasks and lane sources
module prx_lane_align_status_bench
    import prx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, er;
    prx_word_s [3:0] lane_in;
    logic [3:0] lock, serr, sp, rep;
    logic [3:0][7:0] bip;
    logic [3:0][1:0] ix;
    logic [3:0] run = 4'h0;
    logic [3:0] add = 4'h0;
    logic [7:0] bad [4] = '{default: 8'h00};
    logic [7:0] last_bip [4];
    int n_bip [4] = '{default: 0};
    int n_sp [4] = '{default: 0};
    int n_rep [4] = '{default: 0};
    int n_fail = 0;
    int n_compared = 0;
    int k;

    always #2.5 pclk = ~pclk;

    // Physical lane p carries PCS lane 3-p, so the mapping is not trivial
    for (genvar p = 0; p < 4; p++) begin : g_src
        prx_lane_src i_src (.pclk(pclk), .presetn(presetn), .run(run[p]), .add_short(add[p]),
            .id(2'(3 - p)), .bad(bad[p]), .ivl(16'h7), .w(lane_in[p]));
    end

    prx_lane_align_status i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .lane_in(lane_in), .lane_marker_lock(lock),
        .sync_error(serr), .marker_spacing_error(sp), .marker_repeat_error(rep),
        .bip_error(bip), .pcs_lane0_phys_index(ix[0]), .pcs_lane1_phys_index(ix[1]),
        .pcs_lane2_phys_index(ix[2]), .pcs_lane3_phys_index(ix[3]));

    // ********
    // Tasks
    // ********
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic tmo(int j);
        if (j >= 200) begin
            n_fail++;
            print_verdict();
        end
    endtask : tmo

    task automatic check(string n, logic [32:0] s, logic [32:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // One APB transfer; the request stands until ready is sampled high
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int j;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (j = 0; j < 200; j++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        tmo(j);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(string n, logic [11:0] a, logic [32:0] e);
        apb(1'b0, a, 32'h0);
        check(n, {er, rd}, e);
    endtask : rchk

    // Pulse counters per PCS lane; counting waits for reset release because
    // the outputs are still unknown at the first edge
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            for (int v = 0; v < 4; v++) begin
                if (bip[v] !== 8'h00) begin
                    n_bip[v]++;
                    last_bip[v] = bip[v];
                end
                if (sp[v] === 1'b1) n_sp[v]++;
                if (rep[v] === 1'b1) n_rep[v]++;
            end
        end
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl", 12'h000, 33'h3FFF);
        rchk("lock", 12'h004, 33'h00F0);
        rchk("hole", 12'h014, 33'h100000000);
        apb(1'b1, 12'h000, 32'h7);
        rchk("ctrl", 12'h000, 33'h7);
        $display("reset test done");
        run <= 4'hF;
        for (k = 0; k < 200 && lock !== 4'hF; k++) @(posedge pclk);
        tmo(k);
        check("index", ix, 8'h1B);
        rchk("lock", 12'h004, 33'h1B0F);
        rchk("ist", 12'h008, 33'h0);
        apb(1'b1, 12'h00C, 32'hFFFF);
        $display("lock test done");
        bad[0] <= 8'h5A;
        for (k = 0; k < 200 && n_bip[3] == 0; k++) @(posedge pclk);
        tmo(k);
        bad[0] <= 8'h00;
        repeat (20) @(posedge pclk);
        check("bip count", n_bip[3], 1);
        check("bip value", last_bip[3], 8'h5A);
        check("bip other", n_bip[0] + n_bip[1] + n_bip[2], 0);
        check("irq", irq, 1'b1);
        rchk("ist", 12'h008, 33'h8);
        apb(1'b1, 12'h010, 32'h8);
        rchk("ist", 12'h008, 33'h0);
        check("irq", irq, 1'b0);
        $display("parity test done");
        for (k = 0; k < 200 && lane_in[1].marker !== 1'b1; k++) @(posedge pclk);
        tmo(k);
        add[1] <= 1'b1;
        @(posedge pclk);
        add[1] <= 1'b0;
        for (k = 0; k < 200 && n_rep[2] == 0; k++) @(posedge pclk);
        tmo(k);
        repeat (20) @(posedge pclk);
        check("spacing", n_sp[2], 4);
        check("repeat", n_rep[2], 1);
        apb(1'b1, 12'h00C, 32'h0);
        rchk("ist", 12'h008, 33'h440);
        check("irq masked", irq, 1'b0);
        apb(1'b1, 12'h00C, 32'h40);
        rchk("ist", 12'h008, 33'h440);
        check("irq", irq, 1'b1);
        apb(1'b1, 12'h010, 32'h440);
        rchk("ist", 12'h008, 33'h0);
        check("irq", irq, 1'b0);
        $display("spacing test done");
        run[3] <= 1'b0;
        for (k = 0; k < 200 && lock[0] !== 1'b0; k++) @(posedge pclk);
        tmo(k);
        check("sync", serr, 4'h1);
        check("index0", ix[0], 2'h3);
        rchk("lock", 12'h004, 33'h1B1E);
        rchk("ist", 12'h008, 33'h1000);
        $display("lock loss test done");
        print_verdict();
    end
endmodule : prx_lane_align_status_bench

//--- testbench/prx_lane_src.sv
// Word source model of one physical receive lane
module prx_lane_src
    import prx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic add_short,
    input wire logic [1:0] id,
    input wire logic [7:0] bad,
    input wire logic [15:0] ivl,
    output prx_word_s w
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt;
    logic [2:0] left;
    logic mk;

    // Short windows are spent first, one per marker
    assign mk = run && cnt == ((left != 3'h0) ? ivl - 16'h1 : ivl);

    // Words run every cycle while framed; lock loss restarts the window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0;
            left <= 3'h0;
        end else begin
            cnt <= (mk || !run) ? 16'h0 : cnt + 16'h1;
            if (add_short) begin
                left <= 3'h4;
            end else if (mk && left != 3'h0) begin
                left <= left - 3'h1;
            end
        end
    end

    // Marker fields outside markers carry a moving pattern, never a stale value
    assign w = mk ? {run, run, 1'b1, id, 8'hA5, 8'hA5 ^ bad}
                  : {run, run, 1'b0, ~cnt[1:0], cnt[7:0], ~cnt[7:0]};
endmodule : prx_lane_src

//--- testbench/prx_las_checker.sv
// Port checker of the lane alignment status block
module prx_las_checker
    import prx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire prx_word_s [3:0] lane_in,
    input wire logic [3:0] lane_marker_lock,
    input wire logic [3:0] sync_error,
    input wire logic [3:0] marker_spacing_error,
    input wire logic [3:0] marker_repeat_error,
    input wire logic [3:0][7:0] bip_error,
    input wire logic [1:0] pcs_lane0_phys_index,
    input wire logic [1:0] pcs_lane2_phys_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Properties
    // ********
    prx_word_s [3:0] d1_reg;
    prx_word_s [3:0] d2_reg;

    // Lane words two edges back, matching the lock latency
    always_ff @(posedge pclk) begin
        d1_reg <= lane_in;
        d2_reg <= d1_reg;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_sync_inverse: assert property (sync_error == ~lane_marker_lock)
        else $error("sync error not inverse of lock");
    chk_lock_cause: assert property ($rose(lane_marker_lock[2]) |->
        d2_reg[pcs_lane2_phys_index].marker && d2_reg[pcs_lane2_phys_index].marker_id == 2'h2)
        else $error("lane 2 lock without marker");
    chk_index_hold: assert property (!lane_marker_lock[0] ##1 !lane_marker_lock[0] |->
        $stable(pcs_lane0_phys_index)) else $error("index moved while unlocked");
    chk_spacing_once: assert property (marker_spacing_error != 4'h0 |=>
        (marker_spacing_error & $past(marker_spacing_error)) == 4'h0) else $error("long pulse");
    chk_repeat_pulse: assert property (marker_repeat_error != 4'h0 |->
        (marker_repeat_error & ~marker_spacing_error) == 4'h0 ##1 marker_repeat_error == 4'h0)
        else $error("repeat pulse wrong");
    chk_bip_once: assert property (bip_error[3] != 8'h00 |=> bip_error[3] == 8'h00)
        else $error("parity pulse too long");
    chk_ready_access: assert property (psel && !penable |=> pready)
        else $error("no ready in access");
    chk_error_map: assert property (pready |-> pslverr == (paddr > 12'h010 || paddr[1:0] != 2'h0))
        else $error("error response wrong");
    chk_read_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
endmodule : prx_las_checker

bind prx_lane_align_status prx_las_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_in(lane_in), .lane_marker_lock(lane_marker_lock), .sync_error(sync_error),
    .marker_spacing_error(marker_spacing_error), .marker_repeat_error(marker_repeat_error),
    .bip_error(bip_error), .pcs_lane0_phys_index(pcs_lane0_phys_index),
    .pcs_lane2_phys_index(pcs_lane2_phys_index));
